// *** core/tws_eeprom.sv ***
// two-wire serial eeprom slave engine
module tws_eeprom #(
  parameter int NV_PROGRAM_CYCLES = tws_pkg::NV_PROGRAM_CYCLES
) (
  input  wire logic clk,        // system clock, 20 MHz
  input  wire logic resetn,     // async reset, active low
  input  wire logic serialClk,  // serial clock from host
  input  wire logic sdaIn,      // data line level
  output logic      sdaOut,     // data drive value, always low
  output logic      sdaOe,      // high while pulling data low
  output logic      standby     // low-power standby state
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic rstClkN;   // reset copy, system domain
  logic rstLinkN;  // reset copy, link domain

  // array, written in system domain, read by link domain
  logic [7:0] mem      [tws_pkg::MEM_DEPTH];  // storage
  logic [7:0] next_mem [tws_pkg::MEM_DEPTH];  // next storage

  // start and stop event toggles, clocked by the data line
  logic startTgl;  // flips on each start
  logic stopTgl;   // flips on each stop

  // link domain: rising edge sampling
  logic [7:0] rxShift;       // received bits
  logic [7:0] next_rxShift;  // next received bits
  logic       sdaRise;       // data at last rising edge
  logic       next_sdaRise;  // next sampled data

  // link domain: falling edge engine
  tws_pkg::tws_state_e state;       // word state
  tws_pkg::tws_state_e next_state;  // next word state
  logic [3:0]  bitCnt;         // falling edges in word
  logic [3:0]  next_bitCnt;
  logic [tws_pkg::ADDR_W-1:0] addr;       // word address
  logic [tws_pkg::ADDR_W-1:0] next_addr;
  logic [7:0]  txShift;        // outgoing byte
  logic [7:0]  next_txShift;
  logic        ackDrive;       // pulling data low
  logic        next_ackDrive;
  logic        startSeen;      // start toggle consumed
  logic        next_startSeen;
  logic        stopSeen;       // stop toggle consumed
  logic        next_stopSeen;
  logic        wrWait;         // program cycle pending
  logic        next_wrWait;
  logic        doneSeen;       // done toggle consumed
  logic        next_doneSeen;
  logic [tws_pkg::ROW_W-1:0]      bufRow;  // page row held
  logic [tws_pkg::ROW_W-1:0]      next_bufRow;
  logic [tws_pkg::PAGE_SLOTS-1:0] bufMask; // filled page slots
  logic [tws_pkg::PAGE_SLOTS-1:0] next_bufMask;
  logic [7:0] bufData      [tws_pkg::PAGE_SLOTS];  // page bytes
  logic [7:0] next_bufData [tws_pkg::PAGE_SLOTS];
  logic       doneLink;        // done toggle, synchronised

  // system domain
  logic startSys;        // start toggle, synchronised
  logic stopSys;         // stop toggle, synchronised
  logic startSeenSys;    // start toggle consumed
  logic next_startSeenSys;
  logic stopSeenSys;     // stop toggle consumed
  logic next_stopSeenSys;
  logic busBusy;         // between start and stop
  logic next_busBusy;
  logic busy;            // program cycle running
  logic next_busy;
  logic committed;       // page already programmed
  logic next_committed;
  logic doneTgl;         // flips when programming ends
  logic next_doneTgl;
  logic tmrStart;        // launch pulse
  logic next_tmrStart;
  logic tmrDone;         // end pulse
  logic next_standby;

  ////////////////////////////////////////////////////////////////////////////
  // reset release, one copy per domain
  tws_sync uRstClk (
    .clk  (clk),
    .rstN (resetn),
    .d    (1'b1),
    .q    (rstClkN)
  );

  tws_sync uRstLink (
    .clk  (serialClk),
    .rstN (resetn),
    .d    (1'b1),
    .q    (rstLinkN)
  );

  ////////////////////////////////////////////////////////////////////////////
  // start and stop detection on data edges while clock high
  always_ff @(negedge sdaIn or negedge rstClkN) begin
    if (!rstClkN) begin
      startTgl <= 1'b0;
    end else if (serialClk) begin
      startTgl <= ~startTgl;
    end
  end

  always_ff @(posedge sdaIn or negedge rstClkN) begin
    if (!rstClkN) begin
      stopTgl <= 1'b0;
    end else if (serialClk) begin
      stopTgl <= ~stopTgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rising edge: shift in one bit, msb first
  always_comb begin
    next_rxShift = {rxShift[6:0], sdaIn};
    next_sdaRise = sdaIn;
  end

  always_ff @(posedge serialClk or negedge rstLinkN) begin
    if (!rstLinkN) begin
      rxShift <= 8'h00;
      sdaRise <= 1'b1;
    end else begin
      rxShift <= next_rxShift;
      sdaRise <= next_sdaRise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // done toggle into the link domain
  tws_sync uDoneLink (
    .clk  (serialClk),
    .rstN (rstLinkN),
    .d    (doneTgl),
    .q    (doneLink)
  );

  ////////////////////////////////////////////////////////////////////////////
  // falling edge: word engine, acknowledge and output shifting
  always_comb begin
    next_state     = state;
    next_bitCnt    = bitCnt;
    next_addr      = addr;
    next_txShift   = txShift;
    next_ackDrive  = ackDrive;
    next_startSeen = startSeen;
    next_stopSeen  = stopSeen;
    next_wrWait    = wrWait;
    next_doneSeen  = doneSeen;
    next_bufRow    = bufRow;
    next_bufMask   = bufMask;
    next_bufData   = bufData;
    // program cycle over: page buffer free again
    if (wrWait && (doneLink != doneSeen)) begin
      next_wrWait   = 1'b0;
      next_bufMask  = '0;
      next_doneSeen = doneLink;
    end
    // stop: drop everything, lock out while programming
    if (stopTgl != stopSeen) begin
      next_stopSeen  = stopTgl;
      next_state     = tws_pkg::ST_IDLE;
      next_ackDrive  = 1'b0;
      if ((next_bufMask != '0) && !next_wrWait) begin
        next_wrWait   = 1'b1;
        next_doneSeen = doneLink;
      end
    end
    if (startTgl != startSeen) begin
      // start: new word begins at the next rising edge
      next_startSeen = startTgl;
      next_state     = tws_pkg::ST_ADDR;
      next_bitCnt    = 4'h0;
      next_ackDrive  = 1'b0;
    end else begin
      case (state)
        tws_pkg::ST_ADDR: begin
          if (bitCnt == tws_pkg::CNT_LAST_BIT) begin
            if (next_wrWait) begin
              // busy programming: no ack, ignore transfer
              next_state = tws_pkg::ST_IDLE;
            end else begin
              next_addr     = rxShift[7:1];
              next_ackDrive = 1'b1;
              next_bitCnt   = tws_pkg::CNT_ACK;
              if (!rxShift[0]) begin
                // write: fresh page buffer
                next_bufRow  = rxShift[7:3];
                next_bufMask = '0;
              end
            end
          end else if (bitCnt == tws_pkg::CNT_ACK) begin
            next_bitCnt   = 4'h0;
            next_ackDrive = 1'b0;
            if (rxShift[1]) begin
              // read: first byte from the address itself
              next_state    = tws_pkg::ST_DOUT;
              next_txShift  = mem[addr];
              next_ackDrive = ~mem[addr][7];
            end else begin
              next_state = tws_pkg::ST_DIN;
            end
          end else begin
            next_bitCnt = bitCnt + 4'h1;
          end
        end
        tws_pkg::ST_DIN: begin
          if (bitCnt == tws_pkg::CNT_LAST_BIT) begin
            // store byte, advance within the page only
            next_bufData[addr[1:0]] = rxShift;
            next_bufMask[addr[1:0]] = 1'b1;
            next_addr[1:0]          = addr[1:0] + 2'h1;
            next_ackDrive           = 1'b1;
            next_bitCnt             = tws_pkg::CNT_ACK;
          end else if (bitCnt == tws_pkg::CNT_ACK) begin
            next_ackDrive = 1'b0;
            next_bitCnt   = 4'h0;
          end else begin
            next_bitCnt = bitCnt + 4'h1;
          end
        end
        tws_pkg::ST_DOUT: begin
          if (bitCnt < tws_pkg::CNT_LAST_BIT) begin
            // shift next bit out on the falling edge
            next_txShift  = {txShift[6:0], 1'b0};
            next_ackDrive = ~txShift[6];
            next_bitCnt   = bitCnt + 4'h1;
          end else if (bitCnt == tws_pkg::CNT_LAST_BIT) begin
            next_ackDrive = 1'b0;
            next_bitCnt   = tws_pkg::CNT_ACK;
          end else if (!sdaRise) begin
            // host ack: next byte, full wrap
            next_addr     = addr + 7'h01;
            next_txShift  = mem[addr + 7'h01];
            next_ackDrive = ~mem[addr + 7'h01][7];
            next_bitCnt   = 4'h0;
          end else begin
            // no host ack: release and wait for stop
            next_state  = tws_pkg::ST_IDLE;
            next_bitCnt = 4'h0;
          end
        end
        default: begin
          next_ackDrive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(negedge serialClk or negedge rstLinkN) begin
    if (!rstLinkN) begin
      state     <= tws_pkg::ST_IDLE;
      bitCnt    <= 4'h0;
      addr      <= '0;
      txShift   <= 8'h00;
      ackDrive  <= 1'b0;
      startSeen <= 1'b0;
      stopSeen  <= 1'b0;
      wrWait    <= 1'b0;
      doneSeen  <= 1'b0;
      bufRow    <= '0;
      bufMask   <= '0;
      for (int i = 0; i < tws_pkg::PAGE_SLOTS; i++) begin
        bufData[i] <= 8'h00;
      end
    end else begin
      state     <= next_state;
      bitCnt    <= next_bitCnt;
      addr      <= next_addr;
      txShift   <= next_txShift;
      ackDrive  <= next_ackDrive;
      startSeen <= next_startSeen;
      stopSeen  <= next_stopSeen;
      wrWait    <= next_wrWait;
      doneSeen  <= next_doneSeen;
      bufRow    <= next_bufRow;
      bufMask   <= next_bufMask;
      bufData   <= next_bufData;
    end
  end

  // open-drain pin: drive value fixed low
  assign sdaOut = 1'b0;
  assign sdaOe  = ackDrive;

  ////////////////////////////////////////////////////////////////////////////
  // event toggles into the system domain
  tws_sync uStartSys (
    .clk  (clk),
    .rstN (rstClkN),
    .d    (startTgl),
    .q    (startSys)
  );

  tws_sync uStopSys (
    .clk  (clk),
    .rstN (rstClkN),
    .d    (stopTgl),
    .q    (stopSys)
  );

  tws_wr_timer #(
    .CYCLES (NV_PROGRAM_CYCLES)
  ) uTimer (
    .clk   (clk),
    .rstN  (rstClkN),
    .start (tmrStart),
    .done  (tmrDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // system domain: commit page on stop, time the cycle, standby
  always_comb begin
    next_mem          = mem;
    next_startSeenSys = startSys;
    next_stopSeenSys  = stopSys;
    next_busBusy      = busBusy;
    next_busy         = busy;
    next_committed    = committed;
    next_doneTgl      = doneTgl;
    next_tmrStart     = 1'b0;
    // page buffer emptied by the link side
    if (bufMask == '0) begin
      next_committed = 1'b0;
    end
    if (stopSys != stopSeenSys) begin
      next_busBusy = 1'b0;
      if ((bufMask != '0) && !busy && !committed) begin
        // program filled slots, timing starts at the stop
        for (int s = 0; s < tws_pkg::PAGE_SLOTS; s++) begin
          if (bufMask[s]) begin
            next_mem[{bufRow, tws_pkg::SLOT_W'(s)}] = bufData[s];
          end
        end
        next_busy      = 1'b1;
        next_committed = 1'b1;
        next_tmrStart  = 1'b1;
      end
    end
    if (startSys != startSeenSys) begin
      next_busBusy = 1'b1;
    end
    if (tmrDone) begin
      next_busy    = 1'b0;
      next_doneTgl = ~doneTgl;
    end
    next_standby = !next_busBusy && !next_busy;
  end

  always_ff @(posedge clk) begin
    mem <= next_mem;
  end

  always_ff @(posedge clk or negedge rstClkN) begin
    if (!rstClkN) begin
      startSeenSys <= 1'b0;
      stopSeenSys  <= 1'b0;
      busBusy      <= 1'b0;
      busy         <= 1'b0;
      committed    <= 1'b0;
      doneTgl      <= 1'b0;
      tmrStart     <= 1'b0;
      standby      <= 1'b1;
    end else begin
      startSeenSys <= next_startSeenSys;
      stopSeenSys  <= next_stopSeenSys;
      busBusy      <= next_busBusy;
      busy         <= next_busy;
      committed    <= next_committed;
      doneTgl      <= next_doneTgl;
      tmrStart     <= next_tmrStart;
      standby      <= next_standby;
    end
  end

endmodule // tws_eeprom

// *** include/tws_pkg.sv ***
// How it works
// - data moves only while clock low
// - data falling, clock high: start condition
// - data rising, clock high: stop, ends all
// - standby at power-up and after stop
// - eight-bit words, receiver acks ninth clock
// - device acks address words and written data words
// - byte write: address, low bit, data
// - write cycle timed from the stop
// - inputs ignored while write cycle runs
// - page write: up to four acked bytes
// - only low two address bits increment
// - over four bytes wraps and overwrites
// - polling: ack only after write finishes
// - read: direction bit set to one
// - byte read: ack, then eight bits out
// - host ack advances address, next byte
// - read address wraps top to bottom
// - sample on rising, shift on falling
// - 128 bytes, seven-bit word address
package tws_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // array shape
  localparam int ADDR_W     = 7;    // word address width
  localparam int MEM_DEPTH  = 128;  // bytes in the array
  localparam int SLOT_W     = 2;    // in-page address bits
  localparam int ROW_W      = 5;    // page row bits
  localparam int PAGE_SLOTS = 4;    // bytes per page

  ////////////////////////////////////////////////////////////////////////////
  // bit counter marks within a word
  localparam logic [3:0] CNT_LAST_BIT = 4'h7;  // eighth bit just sampled
  localparam logic [3:0] CNT_ACK      = 4'h8;  // ninth clock slot

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS   = 50;          // system clock period
  localparam int NV_PROGRAM_NS   = 10_000_000;  // nv_program_duration, 10 ms
  localparam int NV_PROGRAM_CYCLES = NV_PROGRAM_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // link state machine
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,  // waiting for start
    ST_ADDR = 4'h2,  // address word
    ST_DIN  = 4'h4,  // write data words
    ST_DOUT = 4'h8   // read data words
  } tws_state_e;

endpackage

// *** core/tws_sync.sv ***
// two flip-flop level synchroniser
module tws_sync (
  input  wire logic clk,   // destination clock
  input  wire logic rstN,  // async reset, active low
  input  wire logic d,     // level from another domain
  output logic      q      // synchronised level
);

  logic meta;      // first stage, read only by q
  logic next_meta; // next first stage

  // shift the level through two stages
  always_comb begin
    next_meta = d;
  end

  // register both stages
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= next_meta;
      q    <= meta;
    end
  end

endmodule // tws_sync

// *** core/tws_wr_timer.sv ***
// self-timed program cycle counter
module tws_wr_timer #(
  parameter int CYCLES = 4
) (
  input  wire logic clk,    // system clock
  input  wire logic rstN,   // async reset, active low
  input  wire logic start,  // one-cycle launch pulse
  output logic      done    // one-cycle end pulse
);

  logic [31:0] count;       // cycles left
  logic [31:0] next_count;  // next cycles left
  logic        next_done;   // next end pulse

  // load on launch, count down, pulse at one
  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (start) begin
      next_count = 32'(CYCLES);
    end else if (count == 32'h00000001) begin
      next_count = 32'h00000000;
      next_done  = 1'b1;
    end else if (count != 32'h00000000) begin
      next_count = count - 32'h00000001;
    end
  end

  // register counter and pulse
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count <= 32'h00000000;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= next_done;
    end
  end

endmodule // tws_wr_timer

// *** bench/tws_eeprom_asserts.sv ***
// protocol checker for the eeprom slave engine
module tws_eeprom_asserts #(
  parameter int NV_PROGRAM_CYCLES = 4
) (
  input wire logic clk,        // system clock
  input wire logic resetn,     // async reset, active low
  input wire logic serialClk,  // host serial clock
  input wire logic sdaIn,      // resolved data line
  input wire logic sdaOut,     // drive value
  input wire logic sdaOe,      // drive enable
  input wire logic standby     // standby flag
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // helper state
  logic       startTgl;  // flips on each start
  logic       seenTgl;   // start taken by counter
  logic       framed;    // a start was seen
  logic       rd;        // direction of frame
  logic       addrAck;   // address word acked
  logic [3:0] cnt;       // rising edge in word
  logic [1:0] word;      // word index, saturating
  int         idleCnt;   // idle bus cycles while awake
  logic       live;      // inside a counted frame

  assign live = framed && (startTgl == seenTgl);

  // start marker
  always_ff @(negedge sdaIn or negedge resetn) begin
    if (!resetn)
      startTgl <= 1'h0;
    else if (serialClk)
      startTgl <= ~startTgl;
  end

  // bit and word position
  always_ff @(posedge serialClk or negedge resetn) begin
    if (!resetn) begin
      seenTgl <= 1'h0;
      framed  <= 1'h0;
      rd      <= 1'h0;
      cnt     <= 4'h0;
      word    <= 2'h0;
    end else if (startTgl != seenTgl) begin
      seenTgl <= startTgl;
      framed  <= 1'h1;
      cnt     <= 4'h1;
      word    <= 2'h0;
    end else begin
      cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
      if (cnt == 4'h9 && word != 2'h3)
        word <= word + 2'h1;
      if (cnt == 4'h7 && word == 2'h0)
        rd <= sdaIn;
    end
  end

  // address acknowledge record
  always_ff @(negedge serialClk or negedge resetn) begin
    if (!resetn)
      addrAck <= 1'h0;
    else if (cnt == 4'h9 && word == 2'h0)
      addrAck <= sdaOe;
  end

  // idle bus with device awake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      idleCnt <= 0;
    else if (!standby && serialClk && sdaIn)
      idleCnt <= idleCnt + 1;
    else
      idleCnt <= 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_drive_zero: assert property (
    @(posedge clk) disable iff (!resetn) sdaOe |-> !sdaOut)
    else $error("drive value not low");
  a_quiet_standby: assert property (
    @(posedge clk) disable iff (!resetn) standby |-> !sdaOe)
    else $error("driving in standby");
  a_start_wakes: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(sdaIn) && serialClk && $past(serialClk) |-> ##[1:5] !standby)
    else $error("start did not wake");
  a_idle_bounded: assert property (
    @(posedge clk) disable iff (!resetn) idleCnt <= NV_PROGRAM_CYCLES + 8)
    else $error("standby not resumed");
  a_addr_released: assert property (
    @(negedge serialClk) disable iff (!resetn)
    live && word == 2'h0 && cnt >= 4'h1 && cnt <= 4'h8 |-> !sdaOe)
    else $error("drive during address bits");
  a_wdata_released: assert property (
    @(negedge serialClk) disable iff (!resetn)
    live && word != 2'h0 && !rd && cnt >= 4'h1 && cnt <= 4'h8 |-> !sdaOe)
    else $error("drive during write bits");
  a_write_acked: assert property (
    @(negedge serialClk) disable iff (!resetn)
    live && word != 2'h0 && !rd && addrAck && cnt == 4'h9 |-> sdaOe)
    else $error("data word not acked");
  a_host_slot_free: assert property (
    @(negedge serialClk) disable iff (!resetn)
    live && word != 2'h0 && rd && cnt == 4'h9 |-> !sdaOe)
    else $error("drive in host ack slot");
endmodule // tws_eeprom_asserts

bind tws_eeprom tws_eeprom_asserts #(.NV_PROGRAM_CYCLES(NV_PROGRAM_CYCLES)) chk (
  .clk(clk), .resetn(resetn), .serialClk(serialClk), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .standby(standby));

// *** bench/tws_host_model.sv ***
// bus master model, clock still outside frames
module tws_host_model (
  output logic      serialClk,  // serial clock, idle high
  output logic      sdaRel,     // high releases data line
  input  wire logic sdaLine     // resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 32;  // half link period

  initial begin
    serialClk = 1'h1;
    sdaRel    = 1'h1;
  end

  // one slot: data set while low, sampled at rise
  task automatic bit_slot(input logic b, output logic got);
    serialClk = 1'h0;
    #(HALF / 2);
    sdaRel = b;
    #(HALF / 2);
    serialClk = 1'h1;
    got = sdaLine;
    #HALF;
    serialClk = 1'h0;
  endtask

  // start from idle
  task automatic start_cond();
    #100;
    sdaRel = 1'h0;
    #100;
    serialClk = 1'h0;
  endtask

  // stop, then bus free time
  task automatic stop_cond();
    #(HALF / 2);
    sdaRel = 1'h0;
    #(HALF / 2);
    serialClk = 1'h1;
    #100;
    sdaRel = 1'h1;
    #1100;
  endtask

  // word out, then ack slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic unused;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], unused);
    bit_slot(1'h1, ack);
  endtask

  // word in, then our ack or nack
  task automatic recv_byte(input logic ackIt, output logic [7:0] b);
    logic got;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'h1, got);
      b[i] = got;
    end
    bit_slot(!ackIt, got);
  endtask

  // nine released clocks, line must read high
  task automatic recover(output logic ok);
    logic got;
    ok = 1'h1;
    repeat (9) begin
      bit_slot(1'h1, got);
      ok = ok & got;
    end
    #HALF;
    serialClk = 1'h1;
    #1100;
  endtask
endmodule // tws_host_model

// *** bench/tws_eeprom_tb_top.sv ***
// self-checking bench for the eeprom slave engine
module tws_eeprom_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NV_CYC = 60;  // shortened program time

  logic clk;         // system clock
  logic resetn;      // reset, active low
  logic serialClk;   // from host
  logic sdaRel;      // host release
  logic sdaOut;      // device drive value
  logic sdaOe;       // device pull
  logic standby;     // device standby
  wire  sdaIn;       // pulled-up wired-AND line
  int   n_mismatch;  // mismatches
  int   compares;    // comparisons

  // open drain: device shows its drive value only while enabled
  assign sdaIn = sdaRel & (sdaOe ? sdaOut : 1'h1);

  tws_eeprom #(.NV_PROGRAM_CYCLES(NV_CYC)) uut (
    .clk(clk), .resetn(resetn), .serialClk(serialClk), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .standby(standby));
  tws_host_model host (.serialClk(serialClk), .sdaRel(sdaRel), .sdaLine(sdaIn));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // checking
  task automatic note(input logic ok, input string msg);
    compares++;
    if (!ok) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    note(got === exp, $sformatf("bit %b not %b", got, exp));
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, $sformatf("byte %h not %h", got, exp));
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // bounded wait for standby level
  task automatic wait_standby(input logic exp);
    for (int i = 0; i < 200 && standby !== exp; i++)
      @(negedge clk);
    if (standby !== exp) begin
      note(1'h0, "standby wait ran out");
      tally_and_finish();
    end
  endtask

  // poll until the address is acked
  task automatic poll_ready(input logic [6:0] a);
    logic ack;
    ack = 1'h1;
    for (int i = 0; i < 12 && ack !== 1'h0; i++) begin
      host.start_cond();
      host.send_byte({a, 1'h0}, ack);
      host.stop_cond();
    end
    if (ack !== 1'h0) begin
      note(1'h0, "poll ran out");
      tally_and_finish();
    end
  endtask

  task automatic do_write(input logic [6:0] a, input int n, input logic [7:0] base);
    logic ack;
    host.start_cond();
    host.send_byte({a, 1'h0}, ack);
    check_bit(ack, 1'h0);
    for (int i = 0; i < n; i++) begin
      host.send_byte(base + 8'(i), ack);
      check_bit(ack, 1'h0);
    end
    host.stop_cond();
  endtask

  task automatic do_read(input logic [6:0] a, input int n, input logic [7:0] exp [3]);
    logic       ack;
    logic [7:0] got;
    host.start_cond();
    host.send_byte({a, 1'h1}, ack);
    check_bit(ack, 1'h0);
    for (int i = 0; i < n; i++) begin
      host.recv_byte(i < n - 1, got);
      check_byte(got, exp[i]);
    end
    host.stop_cond();
    wait_standby(1'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic sc_wake();
    logic ok;
    check_bit(standby, 1'h1);
    host.recover(ok);
    check_bit(ok, 1'h1);
  endtask

  task automatic sc_byte_write();
    logic ack;
    do_write(7'h7F, 1, 8'hA5);
    repeat (4) @(negedge clk);
    check_bit(standby, 1'h0);
    host.start_cond();
    host.send_byte({7'h7F, 1'h1}, ack);
    host.stop_cond();
    check_bit(ack, 1'h1);
    poll_ready(7'h7F);
    wait_standby(1'h1);
  endtask

  // six bytes from slot 2 wrap in the page
  task automatic sc_page_wrap();
    do_write(7'h02, 6, 8'h13);
    poll_ready(7'h02);
    wait_standby(1'h1);
  endtask

  // address only, then stop: no program cycle
  task automatic sc_abort();
    logic ack;
    host.start_cond();
    host.send_byte({7'h40, 1'h0}, ack);
    check_bit(ack, 1'h0);
    host.stop_cond();
    repeat (10) @(negedge clk);
    check_bit(standby, 1'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk = 1'h0;
    resetn = 1'h0;
    n_mismatch = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    repeat (4) @(negedge clk);
    sc_wake();
    sc_byte_write();
    sc_page_wrap();
    do_read(7'h7F, 3, '{8'hA5, 8'h15, 8'h16});
    do_read(7'h03, 1, '{8'h18, 8'h00, 8'h00});
    sc_abort();
    tally_and_finish();
  end
endmodule // tws_eeprom_tb_top
